// ==== hw/asbsc_step_cfg.sv ====
// Strobed register access was decided locally.
`timescale 1ns/10ps
// Functional notes
// - Bit 15 enables the step when one, disables it when zero.
// - Bits 14:13 gain: 0 gives 1, 1 gives 2, 2 and 3 give 4.
// - Bit 4 negative input: zero analog ground B, one external input 7.
// - Positive codes 0 to 7 connect external input N.
// - Codes 8,9,10 route temp sensor, internal short, test source A.
// - Codes 11 to 14 route supply monitors with their dividers.
// - Codes 8 and above select negative automatically, ignoring bit 4.
// - Step six register at D6h, reset 0006h.
// - Step seven register at D7h, same layout, reset 0007h.
module asbsc_step_cfg (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Step six decoded configuration
	output logic step6_enable_bit,
	output logic [2:0] step6_gain,
	output logic [1:0] step6_neg_route,
	output logic [3:0] step6_pos_input_sel,
	// Step seven decoded configuration
	output logic step7_enable_bit,
	output logic [2:0] step7_gain,
	output logic [1:0] step7_neg_route,
	output logic [3:0] step7_pos_input_sel
);
	import asbsc_pkg::*;

	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Gain code to one-hot factor; code 3 aliases code 2
	function automatic logic [2:0] gain_of(input logic [15:0] r);
		case (r[ASBSC_GAIN_HI:ASBSC_GAIN_LO])
			2'h0: gain_of = ASBSC_GAIN_X1;
			2'h1: gain_of = ASBSC_GAIN_X2;
			default: gain_of = ASBSC_GAIN_X4;
		endcase
	endfunction

	// Internal sources override the negative select bit
	function automatic logic [1:0] neg_of(input logic [15:0] r);
		if (r[ASBSC_POS_HI:ASBSC_POS_LO] >= ASBSC_POS_INTERNAL) begin
			neg_of = ASBSC_NEG_AUTO;
		end else if (r[ASBSC_NEG_BIT]) begin
			neg_of = ASBSC_NEG_EXT7;
		end else begin
			neg_of = ASBSC_NEG_GND;
		end
	endfunction

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [15:0] aux_seq_step6_config_reg;
	logic [15:0] aux_seq_step7_config_reg;

	// Step six register; reserved bits never store so they cannot leak
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_seq_step6_config_reg <= ASBSC_STEP6_RESET;
		end else if (reg_wr && reg_addr == ASBSC_STEP6_ADDR) begin
			aux_seq_step6_config_reg <= reg_wdata & ASBSC_WRITE_MASK;
		end
	end

	// Step seven register, same layout
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_seq_step7_config_reg <= ASBSC_STEP7_RESET;
		end else if (reg_wr && reg_addr == ASBSC_STEP7_ADDR) begin
			aux_seq_step7_config_reg <= reg_wdata & ASBSC_WRITE_MASK;
		end
	end

	// Read data one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd && reg_addr == ASBSC_STEP6_ADDR) begin
			reg_rdata <= aux_seq_step6_config_reg;
		end else if (reg_rd && reg_addr == ASBSC_STEP7_ADDR) begin
			reg_rdata <= aux_seq_step7_config_reg;
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ------------------------------------------------------------
	// Decoded outputs toward the sequencer and mux
	// ------------------------------------------------------------
	// Gain and route come from flops of their own, loaded at the same
	// edge as the register, so no decode logic sits on the mux controls
	logic [2:0] step6_gain_reg;
	logic [2:0] step7_gain_reg;
	logic [1:0] step6_neg_route_reg;
	logic [1:0] step7_neg_route_reg;

	// Step six decode flops; reset values are the decode of 0006h
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			step6_gain_reg <= ASBSC_GAIN_X1;
			step6_neg_route_reg <= ASBSC_NEG_GND;
		end else if (reg_wr && reg_addr == ASBSC_STEP6_ADDR) begin
			step6_gain_reg <= gain_of(reg_wdata);
			step6_neg_route_reg <= neg_of(reg_wdata);
		end
	end

	// Step seven decode flops; reset values are the decode of 0007h
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			step7_gain_reg <= ASBSC_GAIN_X1;
			step7_neg_route_reg <= ASBSC_NEG_GND;
		end else if (reg_wr && reg_addr == ASBSC_STEP7_ADDR) begin
			step7_gain_reg <= gain_of(reg_wdata);
			step7_neg_route_reg <= neg_of(reg_wdata);
		end
	end

	// Enable and input code are plain register bits
	assign step6_enable_bit = aux_seq_step6_config_reg[ASBSC_EN_BIT];
	assign step7_enable_bit = aux_seq_step7_config_reg[ASBSC_EN_BIT];
	assign step6_gain = step6_gain_reg;
	assign step7_gain = step7_gain_reg;
	assign step6_neg_route = step6_neg_route_reg;
	assign step7_neg_route = step7_neg_route_reg;
	// Codes 0..7 pick external input N, 8..14 the internal sources
	assign step6_pos_input_sel = aux_seq_step6_config_reg[ASBSC_POS_HI:ASBSC_POS_LO];
	assign step7_pos_input_sel = aux_seq_step7_config_reg[ASBSC_POS_HI:ASBSC_POS_LO];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	property p_rst6;
		@(posedge ref_clk) $rose(rst_b) |-> aux_seq_step6_config_reg == 16'h0006;
	endproperty
	a_rst6: assert property (p_rst6) else $error("step6 reset value wrong");

	property p_rst7;
		@(posedge ref_clk) $rose(rst_b) |-> aux_seq_step7_config_reg == 16'h0007;
	endproperty
	a_rst7: assert property (p_rst7) else $error("step7 reset value wrong");

	property p_rd6;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == 8'hD6 && !reg_wr) |=> reg_rdata == $past(aux_seq_step6_config_reg);
	endproperty
	a_rd6: assert property (p_rd6) else $error("step6 read mismatch");

	property p_wr7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == 8'hD7) |=> aux_seq_step7_config_reg == ($past(reg_wdata) & 16'hE01F);
	endproperty
	a_wr7: assert property (p_wr7) else $error("step7 write not stored");

	property p_resv;
		@(posedge ref_clk) disable iff (!rst_b) reg_rdata[12:5] == 8'h00;
	endproperty
	a_resv: assert property (p_resv) else $error("reserved bits read nonzero");

	property p_en;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == 8'hD6) |=> step6_enable_bit == $past(reg_wdata[15]);
	endproperty
	a_en: assert property (p_en) else $error("step6 enable not following write");

	property p_gain;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == 8'hD7 && reg_wdata[14]) |=> step7_gain == 3'h4;
	endproperty
	a_gain: assert property (p_gain) else $error("gain code 2/3 not x4");

	property p_neg;
		@(posedge ref_clk) disable iff (!rst_b)
		(step6_pos_input_sel < 4'h8) |-> step6_neg_route == {1'b0, aux_seq_step6_config_reg[4]};
	endproperty
	a_neg: assert property (p_neg) else $error("negative select wrong");

	property p_auto;
		@(posedge ref_clk) disable iff (!rst_b)
		step7_pos_input_sel[3] |-> step7_neg_route == 2'h2;
	endproperty
	a_auto: assert property (p_auto) else $error("auto negative not applied");

	property p_pos;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == 8'hD6) |=> step6_pos_input_sel == $past(reg_wdata[3:0]);
	endproperty
	a_pos: assert property (p_pos) else $error("positive select not stored");

	// ------------------------------------------------------------
	// Reset defaults
	// ------------------------------------------------------------
	// Checked one edge late: the first edge of a run finds the flops unset
	property p_rst_hold6;
		@(posedge ref_clk) !rst_b |=> aux_seq_step6_config_reg == ASBSC_STEP6_RESET;
	endproperty
	a_rst_hold6: assert property (p_rst_hold6) else $error("step6 reset not held");

	property p_rst_hold7;
		@(posedge ref_clk) !rst_b |=> aux_seq_step7_config_reg == ASBSC_STEP7_RESET;
	endproperty
	a_rst_hold7: assert property (p_rst_hold7) else $error("step7 reset not held");

	property p_rst_rdata;
		@(posedge ref_clk) !rst_b |=> reg_rdata == 16'h0000;
	endproperty
	a_rst_rdata: assert property (p_rst_rdata) else $error("read data not cleared");

	property p_rst_dec6;
		@(posedge ref_clk) !rst_b |=>
		step6_gain == ASBSC_GAIN_X1 && step6_neg_route == ASBSC_NEG_GND;
	endproperty
	a_rst_dec6: assert property (p_rst_dec6) else $error("step6 decode not default");

	property p_rst_dec7;
		@(posedge ref_clk) !rst_b |=>
		step7_gain == ASBSC_GAIN_X1 && step7_neg_route == ASBSC_NEG_GND;
	endproperty
	a_rst_dec7: assert property (p_rst_dec7) else $error("step7 decode not default");

	// ------------------------------------------------------------
	// Storage and read path
	// ------------------------------------------------------------
	property p_wr6;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP6_ADDR) |=>
		aux_seq_step6_config_reg == ($past(reg_wdata) & ASBSC_WRITE_MASK);
	endproperty
	a_wr6: assert property (p_wr6) else $error("step6 write not stored");

	// A stray write to the other step or an unmapped address must not leak
	property p_hold6;
		@(posedge ref_clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == ASBSC_STEP6_ADDR) |=> $stable(aux_seq_step6_config_reg);
	endproperty
	a_hold6: assert property (p_hold6) else $error("step6 changed without write");

	property p_hold7;
		@(posedge ref_clk) disable iff (!rst_b)
		!(reg_wr && reg_addr == ASBSC_STEP7_ADDR) |=> $stable(aux_seq_step7_config_reg);
	endproperty
	a_hold7: assert property (p_hold7) else $error("step7 changed without write");

	property p_rd7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr == ASBSC_STEP7_ADDR) |=> reg_rdata == $past(aux_seq_step7_config_reg);
	endproperty
	a_rd7: assert property (p_rd7) else $error("step7 read mismatch");

	// Only the two step addresses answer; everything else reads zero
	property p_rd_miss;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_rd && reg_addr != ASBSC_STEP6_ADDR && reg_addr != ASBSC_STEP7_ADDR) |=>
		reg_rdata == 16'h0000;
	endproperty
	a_rd_miss: assert property (p_rd_miss) else $error("unmapped read nonzero");

	property p_rd_idle;
		@(posedge ref_clk) disable iff (!rst_b)
		!reg_rd |=> reg_rdata == 16'h0000;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data stands too long");

	property p_resv6;
		@(posedge ref_clk) disable iff (!rst_b)
		aux_seq_step6_config_reg[12:5] == 8'h00;
	endproperty
	a_resv6: assert property (p_resv6) else $error("step6 reserved bits stored");

	property p_resv7;
		@(posedge ref_clk) disable iff (!rst_b)
		aux_seq_step7_config_reg[12:5] == 8'h00;
	endproperty
	a_resv7: assert property (p_resv7) else $error("step7 reserved bits stored");

	// ------------------------------------------------------------
	// Decoded controls
	// ------------------------------------------------------------
	property p_en7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP7_ADDR) |=> step7_enable_bit == $past(reg_wdata[15]);
	endproperty
	a_en7: assert property (p_en7) else $error("step7 enable not following write");

	property p_gain6_x1;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP6_ADDR && reg_wdata[14:13] == 2'h0) |=>
		step6_gain == ASBSC_GAIN_X1;
	endproperty
	a_gain6_x1: assert property (p_gain6_x1) else $error("step6 gain code 0 not x1");

	property p_gain6_x2;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP6_ADDR && reg_wdata[14:13] == 2'h1) |=>
		step6_gain == ASBSC_GAIN_X2;
	endproperty
	a_gain6_x2: assert property (p_gain6_x2) else $error("step6 gain code 1 not x2");

	property p_gain6_x4;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP6_ADDR && reg_wdata[14]) |=>
		step6_gain == ASBSC_GAIN_X4;
	endproperty
	a_gain6_x4: assert property (p_gain6_x4) else $error("step6 gain code 2/3 not x4");

	property p_onehot6;
		@(posedge ref_clk) disable iff (!rst_b)
		$onehot(step6_gain);
	endproperty
	a_onehot6: assert property (p_onehot6) else $error("step6 gain not one-hot");

	property p_onehot7;
		@(posedge ref_clk) disable iff (!rst_b)
		$onehot(step7_gain);
	endproperty
	a_onehot7: assert property (p_onehot7) else $error("step7 gain not one-hot");

	property p_ext6;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP6_ADDR && reg_wdata[4] && !reg_wdata[3]) |=>
		step6_neg_route == ASBSC_NEG_EXT7;
	endproperty
	a_ext6: assert property (p_ext6) else $error("step6 negative not input 7");

	property p_gnd7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP7_ADDR && !reg_wdata[4] && !reg_wdata[3]) |=>
		step7_neg_route == ASBSC_NEG_GND;
	endproperty
	a_gnd7: assert property (p_gnd7) else $error("step7 negative not ground");

	property p_neg7;
		@(posedge ref_clk) disable iff (!rst_b)
		(step7_pos_input_sel < ASBSC_POS_INTERNAL) |->
		step7_neg_route == {1'b0, aux_seq_step7_config_reg[ASBSC_NEG_BIT]};
	endproperty
	a_neg7: assert property (p_neg7) else $error("step7 negative select wrong");

	property p_auto6;
		@(posedge ref_clk) disable iff (!rst_b)
		(step6_pos_input_sel >= ASBSC_POS_INTERNAL) |-> step6_neg_route == ASBSC_NEG_AUTO;
	endproperty
	a_auto6: assert property (p_auto6) else $error("step6 auto negative not applied");

	property p_pos7;
		@(posedge ref_clk) disable iff (!rst_b)
		(reg_wr && reg_addr == ASBSC_STEP7_ADDR) |=> step7_pos_input_sel == $past(reg_wdata[3:0]);
	endproperty
	a_pos7: assert property (p_pos7) else $error("step7 positive not stored");
endmodule

// ==== common/asbsc_pkg.sv ====
package asbsc_pkg;
	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] ASBSC_STEP6_ADDR = 8'hD6;
	localparam logic [7:0] ASBSC_STEP7_ADDR = 8'hD7;
	localparam logic [15:0] ASBSC_STEP6_RESET = 16'h0006;
	localparam logic [15:0] ASBSC_STEP7_RESET = 16'h0007;
	localparam logic [15:0] ASBSC_WRITE_MASK = 16'hE01F;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int ASBSC_EN_BIT = 15;
	localparam int ASBSC_GAIN_HI = 14;
	localparam int ASBSC_GAIN_LO = 13;
	localparam int ASBSC_NEG_BIT = 4;
	localparam int ASBSC_POS_HI = 3;
	localparam int ASBSC_POS_LO = 0;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	// Gain factor as a one-hot of {x4, x2, x1}
	localparam logic [2:0] ASBSC_GAIN_X1 = 3'h1;
	localparam logic [2:0] ASBSC_GAIN_X2 = 3'h2;
	localparam logic [2:0] ASBSC_GAIN_X4 = 3'h4;
	// First positive code that forces automatic negative selection
	localparam logic [3:0] ASBSC_POS_INTERNAL = 4'h8;
	// Negative route codes
	localparam logic [1:0] ASBSC_NEG_GND = 2'h0;
	localparam logic [1:0] ASBSC_NEG_EXT7 = 2'h1;
	localparam logic [1:0] ASBSC_NEG_AUTO = 2'h2;
endpackage

// ==== bench/tb.sv ====
`timescale 1ns/10ps
module tb;
	import asbsc_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic s6_en, s7_en;
	logic [2:0] s6_gain, s7_gain;
	logic [1:0] s6_neg, s7_neg;
	logic [3:0] s6_pos, s7_pos;
	logic [15:0] o6, o7;
	logic [15:0] v;
	int error_cnt = 0;
	int checks_done = 0;

	// Free-running 100 MHz clock
	always #5 ref_clk = ~ref_clk;

	// Decoded outputs packed so one compare covers a whole step
	assign o6 = {6'h00, s6_en, s6_gain, s6_neg, s6_pos};
	assign o7 = {6'h00, s7_en, s7_gain, s7_neg, s7_pos};

	asbsc_step_cfg asbsc_step_cfg_i (
		.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.step6_enable_bit(s6_en), .step6_gain(s6_gain), .step6_neg_route(s6_neg),
		.step6_pos_input_sel(s6_pos), .step7_enable_bit(s7_en), .step7_gain(s7_gain),
		.step7_neg_route(s7_neg), .step7_pos_input_sel(s7_pos)
	);

	// ------------------------------------------------------------
	// Bus tasks and checks
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Expected decode, worked out independently of the design
	function automatic logic [15:0] decode(input logic [15:0] r);
		logic [2:0] g;
		logic [1:0] n;
		g = (r[14:13] == 2'h0) ? ASBSC_GAIN_X1 : (r[14:13] == 2'h1) ? ASBSC_GAIN_X2 : ASBSC_GAIN_X4;
		n = (r[3:0] >= 4'h8) ? ASBSC_NEG_AUTO : (r[4] ? ASBSC_NEG_EXT7 : ASBSC_NEG_GND);
		decode = {6'h00, r[15], g, n, r[3:0]};
	endfunction

	// One-cycle write; outputs settle after the closing edge
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// One-cycle read; data stands only in the following cycle
	task automatic rd(input logic [7:0] a, input logic [15:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	task automatic close_out;
		$display("errors %0d checks %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(ASBSC_STEP6_ADDR, ASBSC_STEP6_RESET);
		@(posedge ref_clk);
		#1 chk(reg_rdata, 16'h0000);
		rd(ASBSC_STEP7_ADDR, ASBSC_STEP7_RESET);
		chk(o6, decode(16'h0006));
		chk(o7, decode(16'h0007));
		// All ones exposes the reserved bits and the top code
		wr(ASBSC_STEP6_ADDR, 16'hFFFF);
		rd(ASBSC_STEP6_ADDR, 16'hE01F);
		chk(o6, decode(16'hE01F));
		chk(o7, decode(16'h0007));
		for (int g = 0; g < 4; g++) begin
			v = {1'b1, 2'(g), 8'h00, 1'b1, 4'h5};
			wr(ASBSC_STEP7_ADDR, v);
			chk(o7, decode(v));
		end
		// Every positive code with both negative settings
		for (int c = 0; c < 32; c++) begin
			v = {1'b0, 2'h1, 8'h00, 1'(c >> 4), 4'(c)};
			wr(ASBSC_STEP6_ADDR, v);
			chk(o6, decode(v));
		end
		rd(ASBSC_STEP6_ADDR, 16'h201F);
		// Unmapped neighbours are ignored and read zero
		wr(8'hD5, 16'hFFFF);
		wr(8'hD8, 16'hFFFF);
		rd(8'hD5, 16'h0000);
		rd(8'hD8, 16'h0000);
		rd(ASBSC_STEP7_ADDR, 16'hE015);
		rd(ASBSC_STEP6_ADDR, 16'h201F);
		// A reset in mid-run must bring back the defaults over written values
		@(posedge ref_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_b <= 1'b1;
		rd(ASBSC_STEP6_ADDR, ASBSC_STEP6_RESET);
		rd(ASBSC_STEP7_ADDR, ASBSC_STEP7_RESET);
		chk(o6, decode(ASBSC_STEP6_RESET));
		chk(o7, decode(ASBSC_STEP7_RESET));
		close_out();
	end

	// Guard against a hung run
	initial begin
		#200000;
		error_cnt++;
		$display("run timed out at %0t", $time);
		close_out();
	end
endmodule
